//--- hw/dl_initiator.sv
`default_nettype none
`include "dl_regs.svh"
module dl_initiator
    import dl_pkg::*;
(
    // Clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // Software register port
    input wire logic [7:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    // Status
    output logic o_busy,
    output logic o_irq,
    // Link
    dl_link_if.initiator link
);
    localparam logic [3:0] HALF = 4'(`DL_HALF_CYC);
    dl_host_e st_r, st_nxt;
    logic [7:0] addr_r, addr_nxt;
    logic [15:0] wdat_r, wdat_nxt;
    logic [3:0] cmd_r, cmd_nxt;
    logic [3:0] cyc_r, cyc_nxt;
    logic [3:0] cell_r, cell_nxt, ndrv_r, ndrv_nxt, ncell_r, ncell_nxt;
    logic [27:0] tx_r, tx_nxt;
    logic [19:0] rx_r, rx_nxt;
    logic drv_r, drv_nxt, lclk_r, lclk_nxt;
    logic [3:0] dout_r, dout_nxt, stat_r, stat_nxt;
    logic [15:0] rdat_r, rdat_nxt, rdq_r, rdq_nxt;
    logic err_r, err_nxt;
    logic [1:0] isync_r, isync_nxt;
    logic [7:0] dsync_r, dsync_nxt;
    logic go, rd_cmd, word;

    // Sampling of the pins driven by the target
    always_comb
    begin
        isync_nxt = {isync_r[0], link.irq};
        dsync_nxt = {dsync_r[3:0], link.data};
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            isync_r <= 2'h0;
            dsync_r <= 8'h00;
        end
        else if (i_ce)
        begin
            isync_r <= isync_nxt;
            dsync_r <= dsync_nxt;
        end
    end

    // Register writes, frame sequencing, read mux
    always_comb
    begin
        st_nxt = st_r;
        addr_nxt = addr_r;
        wdat_nxt = wdat_r;
        cmd_nxt = cmd_r;
        cyc_nxt = cyc_r + 4'h1;
        cell_nxt = cell_r;
        ndrv_nxt = ndrv_r;
        ncell_nxt = ncell_r;
        tx_nxt = tx_r;
        rx_nxt = rx_r;
        drv_nxt = drv_r;
        lclk_nxt = lclk_r;
        dout_nxt = dout_r;
        stat_nxt = stat_r;
        rdat_nxt = rdat_r;
        err_nxt = err_r;
        go = i_wr && (i_addr == `DL_H_CTRL) && (st_r == H_IDLE);
        rd_cmd = ~i_wdata[`DL_CMD_WR];
        word = i_wdata[`DL_CMD_WORD];
        if (i_wr && st_r == H_IDLE && i_addr == `DL_H_ADDR)
            addr_nxt = i_wdata[7:0];
        if (i_wr && st_r == H_IDLE && i_addr == `DL_H_WDATA)
            wdat_nxt = i_wdata;
        case (st_r)
            H_IDLE:
            begin
                cyc_nxt = 4'h0;
                // Non-blocking read refused without a frame
                if (go && rd_cmd && i_wdata[`DL_CMD_NB] &&
                    i_wdata[3:0] != `DL_CMD_WAKE)
                begin
                    stat_nxt = `DL_ST_ERR;
                    err_nxt = 1'b1;
                end
                else if (go)
                begin
                    // Command, address, data nibbles in order
                    cmd_nxt = i_wdata[3:0];
                    cell_nxt = 4'h0;
                    if (i_wdata[3:0] == `DL_CMD_WAKE)
                        ndrv_nxt = 4'h1;
                    else if (rd_cmd)
                        ndrv_nxt = 4'h3;
                    else
                        ndrv_nxt = word ? 4'h7 : 4'h5;
                    if (i_wdata[3:0] != `DL_CMD_WAKE && rd_cmd)
                        ncell_nxt = word ? 4'h8 : 4'h6;
                    else
                        ncell_nxt = ndrv_nxt + 4'h1;
                    tx_nxt = {i_wdata[3:0], addr_r,
                        word ? wdat_r : {wdat_r[7:0], 8'h00}};
                    dout_nxt = i_wdata[3:0];
                    tx_nxt = {tx_nxt[23:0], 4'h0};
                    rx_nxt = 20'h00000;
                    drv_nxt = 1'b1;
                    lclk_nxt = 1'b0;
                    st_nxt = H_LOW;
                end
            end
            H_LOW:
            begin
                // link clock limit
                // Half period set by the link clock limit
                if (cyc_r == HALF - 4'h1)
                begin
                    lclk_nxt = 1'b1;
                    cyc_nxt = 4'h0;
                    st_nxt = H_HIGH;
                end
            end
            H_HIGH:
            begin
                if (cyc_r == HALF - 4'h1)
                begin
                    // Target data sampled at end of high phase
                    if (cell_r >= ndrv_r)
                        rx_nxt = {rx_r[15:0], dsync_r[7:4]};
                    lclk_nxt = 1'b0;
                    cyc_nxt = 4'h0;
                    cell_nxt = cell_r + 4'h1;
                    drv_nxt = (cell_r + 4'h1 < ndrv_r);
                    dout_nxt = tx_r[27:24];
                    if (cell_r + 4'h1 < ndrv_r)
                        tx_nxt = {tx_r[23:0], 4'h0};
                    st_nxt = (cell_r + 4'h1 == ncell_r) ? H_GAP : H_LOW;
                end
            end
            H_GAP:
            begin
                // Two idle half periods let the target release
                if (cyc_r == HALF + HALF - 4'h1)
                begin
                    stat_nxt = rx_r[3:0];
                    err_nxt = (rx_r[3:0] != `DL_ST_OK);
                    if (~cmd_r[`DL_CMD_WR] && cmd_r != `DL_CMD_WAKE)
                        rdat_nxt = cmd_r[`DL_CMD_WORD] ? rx_r[19:4] :
                            {8'h00, rx_r[11:4]};
                    st_nxt = H_IDLE;
                end
            end
            default:
            begin
                st_nxt = H_IDLE;
                drv_nxt = 1'b0;
                lclk_nxt = 1'b0;
            end
        endcase
        case (i_addr)
            `DL_H_ADDR: rdq_nxt = {8'h00, addr_r};
            `DL_H_WDATA: rdq_nxt = wdat_r;
            `DL_H_CTRL: rdq_nxt = {12'h000, cmd_r};
            `DL_H_STAT: rdq_nxt = {8'h00, stat_r, 1'b0, isync_r[1],
                err_r, st_r != H_IDLE};
            `DL_H_RDATA: rdq_nxt = rdat_r;
            default: rdq_nxt = 16'h0000;
        endcase
        if (!i_rd)
            rdq_nxt = 16'h0000;
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_r <= H_IDLE;
            addr_r <= 8'h00;
            wdat_r <= 16'h0000;
            cmd_r <= 4'h0;
            cyc_r <= 4'h0;
            cell_r <= 4'h0;
            ndrv_r <= 4'h0;
            ncell_r <= 4'h0;
            tx_r <= 28'h0000000;
            rx_r <= 20'h00000;
            drv_r <= 1'b0;
            lclk_r <= 1'b0;
            dout_r <= 4'h0;
            stat_r <= 4'h0;
            rdat_r <= 16'h0000;
            rdq_r <= 16'h0000;
            err_r <= 1'b0;
        end
        else if (i_ce)
        begin
            st_r <= st_nxt;
            addr_r <= addr_nxt;
            wdat_r <= wdat_nxt;
            cmd_r <= cmd_nxt;
            cyc_r <= cyc_nxt;
            cell_r <= cell_nxt;
            ndrv_r <= ndrv_nxt;
            ncell_r <= ncell_nxt;
            tx_r <= tx_nxt;
            rx_r <= rx_nxt;
            drv_r <= drv_nxt;
            lclk_r <= lclk_nxt;
            dout_r <= dout_nxt;
            stat_r <= stat_nxt;
            rdat_r <= rdat_nxt;
            rdq_r <= rdq_nxt;
            err_r <= err_nxt;
        end
    end

    // Link pins and status outputs
    always_comb
    begin
        link.link_clk = lclk_r;
        link.h_data = dout_r;
        link.h_oe_n = ~drv_r;
        o_rdata = rdq_r;
        o_busy = (st_r != H_IDLE);
        o_irq = isync_r[1];
    end
endmodule // dl_initiator
`default_nettype wire

//--- hw/dl_link_if.sv
`default_nettype none
interface dl_link_if;
    logic link_clk;
    logic [3:0] h_data;
    logic h_oe_n;
    logic [3:0] t_data;
    logic t_oe_n;
    logic irq;
    logic [3:0] data;
    // Pull-down wins when neither end drives
    assign data = !h_oe_n ? h_data : (!t_oe_n ? t_data : 4'h0);
    modport target(input link_clk, input data, output t_data,
        output t_oe_n, output irq);
    modport initiator(output link_clk, output h_data, output h_oe_n,
        input data, input irq);
endinterface
`default_nettype wire

//--- hw/dl_pkg.sv
`default_nettype none
package dl_pkg;
    // Power modes of the companion die
    typedef enum logic [1:0] {
        DL_NORMAL = 2'h0,
        DL_STOP = 2'h1,
        DL_SLEEP = 2'h3
    } dl_mode_e;
    // Target frame states
    typedef enum logic [2:0] {
        T_IDLE = 3'h0,
        T_ADDR = 3'h1,
        T_DATA = 3'h3,
        T_RESP = 3'h2
    } dl_tgt_e;
    // Initiator frame states
    typedef enum logic [1:0] {
        H_IDLE = 2'h0,
        H_LOW = 2'h1,
        H_HIGH = 2'h3,
        H_GAP = 2'h2
    } dl_host_e;
endpackage
`default_nettype wire

//--- hw/dl_regs.svh
`ifndef DL_REGS_SVH
`define DL_REGS_SVH
// Clock and link timing
`define DL_CLK_NS 40
`define DL_LINK_NS 320
`define DL_HALF_CYC (`DL_LINK_NS / 2 / `DL_CLK_NS)
`define DL_IDLE_TO 8'h40
// Command nibble fields
`define DL_CMD_WR 0
`define DL_CMD_WORD 1
`define DL_CMD_NB 2
`define DL_CMD_WAKE 4'h8
// Status nibbles
`define DL_ST_OK 4'hA
`define DL_ST_ERR 4'h5
// Window layout
`define DL_MIRROR_OFS 8'h00
`define DL_MIRROR_HI 8'h01
`define DL_VSR_OFS 8'h10
`define DL_BASE_BLK 16'h0200
`define DL_BASE_NB 16'h0300
// Initiator software registers
`define DL_H_ADDR 8'h00
`define DL_H_WDATA 8'h04
`define DL_H_CTRL 8'h08
`define DL_H_STAT 8'h0C
`define DL_H_RDATA 8'h10
`endif

//--- hw/dl_target.sv
// The strobed register port was decided locally.
`default_nettype none
`include "dl_regs.svh"
module dl_target
    import dl_pkg::*;
(
    // Clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // Link
    dl_link_if.target link,
    // Power mode
    input wire dl_mode_e i_mode,
    input wire logic i_wake_req,
    output logic o_wake,
    // Pad controls
    output logic o_clk_pull_en,
    output logic o_data_pull_dn,
    // Peripheral access port
    output logic o_per_wr,
    output logic o_per_rd,
    output logic [15:0] o_per_addr,
    output logic [15:0] o_per_wdata,
    output logic o_per_word,
    input wire logic [15:0] i_per_rdata,
    input wire logic i_per_err,
    // Interrupt sources, mirror bits 1 to 13
    input wire logic [12:0] i_irq_src,
    input wire logic [4:0] i_volt_cond,
    input wire logic [4:0] i_volt_en,
    // Transfer status
    output logic o_txn_done,
    output logic o_txn_err
);
    logic [2:0] csync_r, csync_nxt;
    logic [7:0] dsync_r, dsync_nxt;
    dl_tgt_e st_r, st_nxt;
    logic [3:0] cmd_r, cmd_nxt;
    logic [7:0] addr_r, addr_nxt;
    logic [15:0] wdat_r, wdat_nxt;
    logic [2:0] cnt_r, cnt_nxt;
    logic [19:0] resp_r, resp_nxt;
    logic drv_r, drv_nxt;
    logic [3:0] dout_r, dout_nxt;
    logic [7:0] idle_r, idle_nxt;
    logic [4:0] vflag_r, vflag_nxt;
    logic [4:0] vprev_r, vprev_nxt;
    logic pend_r, pend_nxt;
    logic lerr_r, lerr_nxt;
    logic local_r, local_nxt;
    logic per_wr_r, per_wr_nxt, per_rd_r, per_rd_nxt;
    logic [15:0] paddr_r, paddr_nxt;
    logic done_r, done_nxt, err_r, err_nxt;
    logic wake_r, wake_nxt, irq_r, irq_nxt;
    logic rise, fall, vclr, is_wr, is_word, is_nb, hit_mirror;
    logic [3:0] din, stat;
    logic [15:0] mirror, rval;

    // Stage two of each chain is read by logic, and stage three of the clock chain too
    always_comb
    begin
        csync_nxt = {csync_r[1:0], link.link_clk};
        dsync_nxt = {dsync_r[3:0], link.data};
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            csync_r <= 3'h0;
            dsync_r <= 8'h00;
        end
        else if (i_ce)
        begin
            csync_r <= csync_nxt;
            dsync_r <= dsync_nxt;
        end
    end

    // Edges and fields of the current frame
    always_comb
    begin
        rise = csync_r[1] & ~csync_r[2];
        fall = ~csync_r[1] & csync_r[2];
        din = dsync_r[7:4];
        is_wr = cmd_r[`DL_CMD_WR];
        is_word = cmd_r[`DL_CMD_WORD];
        is_nb = cmd_r[`DL_CMD_NB];
        hit_mirror = ({addr_r[7:1], 1'b0} == `DL_MIRROR_OFS);
        mirror = {2'h0, i_irq_src, |vflag_r};
        rval = !local_r ? i_per_rdata :
            (is_word ? mirror :
            (addr_r == `DL_MIRROR_HI ? {8'h00, mirror[15:8]} :
            {8'h00, mirror[7:0]}));
        stat = (lerr_r | (i_per_err & ~local_r)) ? `DL_ST_ERR : `DL_ST_OK;
    end

    // Frame engine, voltage flags and irq level
    always_comb
    begin
        st_nxt = st_r;
        cmd_nxt = cmd_r;
        addr_nxt = addr_r;
        wdat_nxt = wdat_r;
        cnt_nxt = cnt_r;
        resp_nxt = resp_r;
        drv_nxt = drv_r;
        dout_nxt = dout_r;
        lerr_nxt = lerr_r;
        local_nxt = local_r;
        paddr_nxt = paddr_r;
        err_nxt = err_r;
        idle_nxt = idle_r;
        pend_nxt = 1'b0;
        per_wr_nxt = 1'b0;
        per_rd_nxt = 1'b0;
        done_nxt = 1'b0;
        wake_nxt = 1'b0;
        vclr = 1'b0;
        case (st_r)
            T_IDLE:
            begin
                if (rise)
                begin
                    cmd_nxt = din;
                    cnt_nxt = 3'h0;
                    lerr_nxt = 1'b0;
                    if (din == `DL_CMD_WAKE)
                    begin
                        wake_nxt = (i_mode == DL_STOP);
                        resp_nxt = {`DL_ST_OK, 16'h0000};
                        cnt_nxt = 3'h1;
                        st_nxt = T_RESP;
                    end
                    else
                    begin
                        st_nxt = T_ADDR;
                    end
                end
            end
            T_ADDR:
            begin
                if (rise)
                begin
                    addr_nxt = {addr_r[3:0], din};
                    cnt_nxt = cnt_r + 3'h1;
                    paddr_nxt = (is_nb ? `DL_BASE_NB : `DL_BASE_BLK) +
                        {8'h00, addr_r[3:0], din};
                    // Mirror pair reads are served here, mirror writes are refused, all else but non-blocking reads goes out
                    local_nxt = ({addr_r[3:0], din[3:1]} == 7'h00);
                    if (cnt_r == 3'h1)
                    begin
                        cnt_nxt = 3'h0;
                        if (is_wr)
                        begin
                            st_nxt = T_DATA;
                        end
                        else
                        begin
                            lerr_nxt = is_nb;
                            per_rd_nxt = ~is_nb &
                                ({addr_r[3:0], din[3:1]} != 7'h00);
                            vclr = ~is_nb &&
                                ({addr_r[3:0], din} == `DL_VSR_OFS);
                            pend_nxt = 1'b1;
                            st_nxt = T_RESP;
                        end
                    end
                end
            end
            T_DATA:
            begin
                if (rise)
                begin
                    wdat_nxt = {wdat_r[11:0], din};
                    cnt_nxt = cnt_r + 3'h1;
                    if (cnt_r == (is_word ? 3'h3 : 3'h1))
                    begin
                        lerr_nxt = hit_mirror;
                        per_wr_nxt = ~hit_mirror;
                        pend_nxt = 1'b1;
                        st_nxt = T_RESP;
                    end
                end
            end
            T_RESP:
            begin
                if (fall)
                begin
                    if (cnt_r == 3'h0)
                    begin
                        drv_nxt = 1'b0;
                        done_nxt = 1'b1;
                        st_nxt = T_IDLE;
                    end
                    else
                    begin
                        dout_nxt = resp_r[19:16];
                        resp_nxt = {resp_r[15:0], 4'h0};
                        cnt_nxt = cnt_r - 3'h1;
                        drv_nxt = 1'b1;
                    end
                end
            end
            default:
            begin
                st_nxt = T_IDLE;
                drv_nxt = 1'b0;
            end
        endcase
        if (pend_r)
        begin
            err_nxt = (stat == `DL_ST_ERR);
            if (is_wr || lerr_r)
            begin
                resp_nxt = {stat, 16'h0000};
                cnt_nxt = 3'h1;
            end
            else if (is_word)
            begin
                resp_nxt = {rval, stat};
                cnt_nxt = 3'h5;
            end
            else
            begin
                resp_nxt = {rval[7:0], stat, 8'h00};
                cnt_nxt = 3'h3;
            end
        end
        if (rise || fall || st_r == T_IDLE)
            idle_nxt = 8'h00;
        else if (idle_r != `DL_IDLE_TO)
            idle_nxt = idle_r + 8'h01;
        if (idle_r == `DL_IDLE_TO || i_mode == DL_SLEEP)
        begin
            st_nxt = T_IDLE;
            drv_nxt = 1'b0;
            idle_nxt = 8'h00;
        end
        vflag_nxt = (vflag_r & {5{~vclr}}) | (i_volt_cond & ~vprev_r & i_volt_en);
        vprev_nxt = i_volt_cond;
        case (i_mode)
            DL_NORMAL: irq_nxt = |mirror;
            DL_STOP: irq_nxt = i_wake_req;
            default: irq_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_r <= T_IDLE;
            cmd_r <= 4'h0;
            addr_r <= 8'h00;
            wdat_r <= 16'h0000;
            cnt_r <= 3'h0;
            resp_r <= 20'h00000;
            drv_r <= 1'b0;
            dout_r <= 4'h0;
            idle_r <= 8'h00;
            vflag_r <= 5'h00;
            vprev_r <= 5'h00;
            pend_r <= 1'b0;
            lerr_r <= 1'b0;
            local_r <= 1'b0;
            per_wr_r <= 1'b0;
            per_rd_r <= 1'b0;
            paddr_r <= 16'h0000;
            done_r <= 1'b0;
            err_r <= 1'b0;
            wake_r <= 1'b0;
            irq_r <= 1'b0;
        end
        else if (i_ce)
        begin
            st_r <= st_nxt;
            cmd_r <= cmd_nxt;
            addr_r <= addr_nxt;
            wdat_r <= wdat_nxt;
            cnt_r <= cnt_nxt;
            resp_r <= resp_nxt;
            drv_r <= drv_nxt;
            dout_r <= dout_nxt;
            idle_r <= idle_nxt;
            vflag_r <= vflag_nxt;
            vprev_r <= vprev_nxt;
            pend_r <= pend_nxt;
            lerr_r <= lerr_nxt;
            local_r <= local_nxt;
            per_wr_r <= per_wr_nxt;
            per_rd_r <= per_rd_nxt;
            paddr_r <= paddr_nxt;
            done_r <= done_nxt;
            err_r <= err_nxt;
            wake_r <= wake_nxt;
            irq_r <= irq_nxt;
        end
    end

    // Outputs; pads keep the pull-down in every mode
    always_comb
    begin
        link.t_data = dout_r;
        link.t_oe_n = ~drv_r;
        link.irq = irq_r;
        o_clk_pull_en = (i_mode != DL_SLEEP);
        o_data_pull_dn = 1'b1;
        o_per_wr = per_wr_r;
        o_per_rd = per_rd_r;
        o_per_addr = paddr_r;
        o_per_wdata = is_word ? wdat_r : {8'h00, wdat_r[7:0]};
        o_per_word = is_word;
        o_txn_done = done_r;
        o_txn_err = err_r;
        o_wake = wake_r;
    end
endmodule // dl_target
`default_nettype wire

//--- test/die_link_target_with_irq_bench.sv
`default_nettype none
`include "dl_regs.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_fail++; \
    $display("[ERR] %0t %h %h", $time, (a), (e)); end end
module die_link_target_with_irq_bench import dl_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    dl_mode_e mode = DL_NORMAL;
    logic wake_req = 1'b0;
    logic [15:0] per_rdata = 16'h0000;
    logic [12:0] irq_src = 13'h0000;
    logic [4:0] vcond = 5'h00;
    logic [4:0] ven = 5'h1F;
    logic [15:0] rv, rdata, st, per_addr, per_wdata, cap_a, cap_d;
    logic irq, wake, pull_clk, pull_dn, per_wr;
    logic woke = 1'b0;
    logic per_rd, per_word, t_done, t_err;
    int n_rd = 0;
    int n_done = 0;
    int n_fail = 0;
    int check_count = 0;
    dl_link_if link();
    dl_target u_dl_target (.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1),
        .link(link.target), .i_mode(mode), .i_wake_req(wake_req),
        .o_wake(wake), .o_clk_pull_en(pull_clk), .o_data_pull_dn(pull_dn),
        .o_per_wr(per_wr), .o_per_rd(per_rd), .o_per_addr(per_addr),
        .o_per_wdata(per_wdata), .o_per_word(per_word),
        .i_per_rdata(per_rdata),
        .i_per_err(1'b0), .i_irq_src(irq_src), .i_volt_cond(vcond),
        .i_volt_en(ven), .o_txn_done(t_done), .o_txn_err(t_err));
    dl_initiator u_dl_initiator (.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s),
        .o_rdata(rv), .o_busy(), .o_irq(irq), .link(link.initiator));
    dl_link_checker u_dl_link_checker (.i_clk(i_clk), .i_rst(i_rst),
        .link_clk(link.link_clk), .h_data(link.h_data),
        .h_oe_n(link.h_oe_n), .t_data(link.t_data), .t_oe_n(link.t_oe_n));
    // Clock
    initial forever #20 i_clk = ~i_clk;
    // Peripheral write capture and sticky wake flag
    always @(posedge i_clk)
    begin
        if (per_wr === 1'b1)
        begin
            cap_a <= per_addr;
            cap_d <= per_wdata;
        end
        if (wake === 1'b1)
            woke <= 1'b1;
        // Pulses counted so tasks can judge them later
        if (per_rd === 1'b1)
            n_rd <= n_rd + 1;
        if (t_done === 1'b1)
            n_done <= n_done + 1;
    end
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge i_clk);
        wr_s <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge i_clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge i_clk);
        rd_s <= 1'b0;
        #1;
        rdata = rv;
    endtask
    task automatic xfer(input logic [7:0] o, input logic [15:0] d,
        input logic [7:0] c);
        int n;
        wr(`DL_H_ADDR, {8'h00, o});
        wr(`DL_H_WDATA, d);
        wr(`DL_H_CTRL, {8'h00, c});
        n = 0;
        do
        begin
            rd(`DL_H_STAT);
            n++;
        end
        while (rdata[0] !== 1'b0 && n < 200);
        `CHK(rdata[0], 1'b0)
        st = rdata;
        rd(`DL_H_RDATA);
    endtask
    task automatic t_volt;
        @(posedge i_clk);
        vcond <= 5'h04;
        xfer(8'h00, 16'h0000, 8'h2);
        `CHK(rdata, 16'h0001)
        `CHK(irq, 1'b1)
        xfer(8'h00, 16'h0000, 8'h2);
        `CHK(rdata, 16'h0001)
        `CHK(n_rd, 0)
        xfer(`DL_VSR_OFS, 16'h0000, 8'h0);
        `CHK(st[7:4], 4'hA)
        `CHK(n_rd, 1)
        `CHK(n_done, 3)
        xfer(8'h00, 16'h0000, 8'h2);
        `CHK(rdata, 16'h0000)
        `CHK(irq, 1'b0)
    endtask
    task automatic t_mirror;
        @(posedge i_clk);
        irq_src <= 13'h1A5B;
        xfer(8'h00, 16'h0000, 8'h2);
        `CHK(rdata, 16'h34B6)
        xfer(8'h01, 16'h0000, 8'h0);
        `CHK(rdata, 16'h0034)
        xfer(8'h00, 16'h0000, 8'h0);
        `CHK(rdata, 16'h00B6)
        `CHK(irq, 1'b1)
    endtask
    task automatic t_access;
        xfer(8'h20, 16'hBEEF, 8'h3);
        `CHK(cap_a, 16'h0220)
        `CHK(per_word, 1'b1)
        `CHK(cap_d, 16'hBEEF)
        xfer(8'hFF, 16'h00C3, 8'h5);
        `CHK(cap_a, 16'h03FF)
        `CHK(per_word, 1'b0)
        `CHK(cap_d, 16'h00C3)
        @(posedge i_clk);
        per_rdata <= 16'h5A3C;
        xfer(8'h40, 16'h0000, 8'h2);
        `CHK(rdata, 16'h5A3C)
        xfer(8'h00, 16'h0000, 8'h4);
        `CHK(st[7:4], 4'h5)
        xfer(8'h00, 16'h0001, 8'h3);
        `CHK(st[7:4], 4'h5)
        `CHK(t_err, 1'b1)
    endtask
    task automatic t_modes;
        `CHK(pull_clk, 1'b1)
        @(posedge i_clk);
        mode <= DL_STOP;
        repeat (8) @(posedge i_clk);
        `CHK(irq, 1'b0)
        wake_req <= 1'b1;
        repeat (8) @(posedge i_clk);
        `CHK(irq, 1'b1)
        xfer(8'h00, 16'h0000, 8'h8);
        `CHK(woke, 1'b1)
        @(posedge i_clk);
        mode <= DL_SLEEP;
        repeat (8) @(posedge i_clk);
        `CHK(irq, 1'b0)
        `CHK(pull_clk, 1'b0)
        `CHK(pull_dn, 1'b1)
    endtask
    task automatic print_verdict;
        if (n_fail == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Main sequence, reset held for 16 cycles
    initial
    begin
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        t_volt();
        t_mirror();
        t_access();
        t_modes();
        print_verdict();
    end
    // A hang counts as a mismatch
    initial
    begin
        #400000;
        n_fail++;
        print_verdict();
    end
endmodule // die_link_target_with_irq_bench
`default_nettype wire

//--- test/dl_link_checker.sv
`default_nettype none
module dl_link_checker (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Link wires
    input wire logic link_clk,
    input wire logic [3:0] h_data,
    input wire logic h_oe_n,
    input wire logic [3:0] t_data,
    input wire logic t_oe_n
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // Two drivers on the nibble lines would fight
    property p_one_drv; !(!h_oe_n && !t_oe_n); endproperty
    a_one_drv: assert property (p_one_drv) else $error("both drive");
    // Cell is four clocks high, four low
    property p_high4;
        $rose(link_clk) |-> link_clk [*4] ##1 !link_clk;
    endproperty
    a_high4: assert property (p_high4) else $error("high phase");
    property p_low4; $fell(link_clk) |-> (!link_clk) [*4]; endproperty
    a_low4: assert property (p_low4) else $error("low phase");
    property p_start; $fell(h_oe_n) |-> (!link_clk) [*4]; endproperty
    a_start: assert property (p_start) else $error("frame start");
    // Target answers only after the initiator lets go
    property p_turn; $fell(t_oe_n) |-> h_oe_n; endproperty
    a_turn: assert property (p_turn) else $error("turnaround");
    property p_rel; $fell(t_oe_n) |-> ##[1:48] t_oe_n; endproperty
    a_rel: assert property (p_rel) else $error("no release");
    // Last nibble before release is the status
    property p_stat;
        $rose(t_oe_n) |-> $past(t_data) == 4'hA || $past(t_data) == 4'h5;
    endproperty
    a_stat: assert property (p_stat) else $error("status code");
    // Nibbles hold while the clock is high
    property p_hstab;
        link_clk && $past(link_clk) && !h_oe_n |-> $stable(h_data);
    endproperty
    a_hstab: assert property (p_hstab) else $error("h_data moved");
    property p_tstab;
        link_clk && $past(link_clk) && !t_oe_n && !$past(t_oe_n)
            |-> $stable(t_data);
    endproperty
    a_tstab: assert property (p_tstab) else $error("t_data moved");
endmodule // dl_link_checker
`default_nettype wire
